// *** design/periph_wait_bridge.sv ***
// CPU to peripheral bus bridge that stretches conflict-prone accesses
// What this block does
// - Insert (2+m) times k CPU clock waits
// - Access lasts 3+m+(2+m)k CPU clocks
// - m comes from wait setting bits 2..0
// - Second watchdog mode write uses k=3
// - First watchdog mode write k 1..5
// - Timer reads k=1, compare writes 0..2
// - Timer control read-modify-write k=1 on write
// - Serial buffer writes k 0..18 or 0..20
// - Serial and two-wire status reads k=1
// - Output buffer writes k=1 when disabled
// - Converter control writes and result reads k 1..5, variant 1..2
// - Remainder up to one period rounds down
// - CPU stalls for the whole inserted wait
// - Computed waits are an upper bound
// - Absent main clock holds the wait until the clock returns or reset
// - No-wait access 3+m clocks, setting resets 77H
`default_nettype none

module periph_wait_bridge
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // CPU access request
  input wire logic cpu_req,
  input wire logic [wait_pkg::SEL_W-1:0] cpu_sel,
  input wire logic cpu_write,
  input wire logic [wait_pkg::DATA_W-1:0] cpu_wdata,
  // System wait setting write
  input wire logic setting_we,
  input wire logic [wait_pkg::SET_W-1:0] setting_wdata,
  // Clock ratios and conditions
  input wire logic [wait_pkg::DIV_W-1:0] main_div,
  input wire logic [wait_pkg::DIV_W-1:0] ser_div,
  input wire logic [wait_pkg::DIV_W-1:0] conv_div,
  input wire logic conv_on_main,
  input wire logic ser_rx_hit,
  input wire logic rt_output_enable,
  input wire logic main_osc_running,
  // Peripheral read data
  input wire logic [wait_pkg::DATA_W-1:0] per_rdata,
  // CPU answer
  output logic cpu_ready,
  output logic cpu_done,
  output logic [wait_pkg::DATA_W-1:0] cpu_rdata,
  // Peripheral strobe
  output logic per_strobe,
  output logic per_write,
  output logic [wait_pkg::SEL_W-1:0] per_sel,
  output logic [wait_pkg::DATA_W-1:0] per_wdata,
  // Status
  output logic [wait_pkg::SET_W-1:0] system_wait_setting,
  output logic [wait_pkg::CNT_W-1:0] last_wait
);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,  // Ready for a request
    ST_WAIT = 2'b01,  // Access in progress
    ST_DONE = 2'b11   // Answer cycle
  } state_t;

  state_t state_r, state_nxt;
  logic [wait_pkg::CNT_W-1:0] cnt_r, cnt_nxt;          // Cycles left
  logic [wait_pkg::SET_W-1:0] setting_r, setting_nxt;  // Wait setting
  logic [wait_pkg::CNT_W-1:0] last_r, last_nxt;        // Last wait inserted
  logic [wait_pkg::CNT_W-1:0] total_r, total_nxt;      // Last access length
  logic ready_r, ready_nxt;
  logic done_r, done_nxt;
  logic [wait_pkg::DATA_W-1:0] rdata_r, rdata_nxt;
  logic strobe_r, strobe_nxt;
  logic write_r, write_nxt;
  logic [wait_pkg::SEL_W-1:0] sel_r, sel_nxt;
  logic [wait_pkg::DATA_W-1:0] wdata_r, wdata_nxt;

  // Current m and factor for the offered request
  logic [wait_pkg::M_W-1:0] m_cur;
  logic [wait_pkg::K_W-1:0] k_cur;
  logic [wait_pkg::CNT_W-1:0] wait_cur;
  logic [wait_pkg::CNT_W-1:0] total_cur;
  logic take;

  assign m_cur = setting_r[wait_pkg::M_W-1:0];
  assign take = cpu_req && (state_r == ST_IDLE);

  // ----------------------------------------------------------------
  // Wait factor
  // ----------------------------------------------------------------
  wait_factor_calc u_calc
  (
    .sel(cpu_sel),
    .is_write(cpu_write),
    .m(m_cur),
    .main_div(main_div),
    .ser_div(ser_div),
    .conv_div(conv_div),
    .conv_on_main(conv_on_main),
    .ser_rx_hit(ser_rx_hit),
    .rt_output_enable(rt_output_enable),
    .k(k_cur)
  );

  // Waits and total length; worst case 190 clocks fits the counter
  assign wait_cur = 8'(({4'h0, wait_pkg::M_BASE} + {5'h00, m_cur}) * {3'h0, k_cur});
  assign total_cur = wait_pkg::BASE_CLOCKS + {5'h00, m_cur} + wait_cur;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    setting_nxt = setting_r;
    last_nxt = last_r;
    total_nxt = total_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    rdata_nxt = rdata_r;
    strobe_nxt = 1'b0;
    write_nxt = write_r;
    sel_nxt = sel_r;
    wdata_nxt = wdata_r;
    // Setting takes effect for the next request taken
    if (setting_we)
      setting_nxt = setting_wdata;
    unique case (state_r)
      ST_IDLE:
        if (cpu_req)
        begin
          // Take the request, launch the peripheral strobe
          state_nxt = ST_WAIT;
          cnt_nxt = total_cur - 8'h01;
          last_nxt = wait_cur;
          total_nxt = total_cur;
          ready_nxt = 1'b0;
          strobe_nxt = 1'b1;
          write_nxt = cpu_write;
          sel_nxt = cpu_sel;
          wdata_nxt = cpu_wdata;
        end
      ST_WAIT:
        // Without the main oscillator the count freezes; it resumes when the oscillator runs again
        if (main_osc_running)
        begin
          if (cnt_r == 8'h01)
          begin
            state_nxt = ST_DONE;
            done_nxt = 1'b1;
            ready_nxt = 1'b1;
            rdata_nxt = write_r ? rdata_r : per_rdata;
          end
          else
            cnt_nxt = cnt_r - 8'h01;
        end
      ST_DONE:
        state_nxt = ST_IDLE;
      // Unused code falls back to idle
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r <= ST_IDLE;
      cnt_r <= '0;
      setting_r <= wait_pkg::SET_RESET;
      last_r <= '0;
      total_r <= '0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      rdata_r <= '0;
      strobe_r <= 1'b0;
      write_r <= 1'b0;
      sel_r <= wait_pkg::SEL_PLAIN;
      wdata_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      setting_r <= setting_nxt;
      last_r <= last_nxt;
      total_r <= total_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      rdata_r <= rdata_nxt;
      strobe_r <= strobe_nxt;
      write_r <= write_nxt;
      sel_r <= sel_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  assign cpu_ready = ready_r;
  assign cpu_done = done_r;
  assign cpu_rdata = rdata_r;
  assign per_strobe = strobe_r;
  assign per_write = write_r;
  assign per_sel = sel_r;
  assign per_wdata = wdata_r;
  assign system_wait_setting = setting_r;
  assign last_wait = last_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Clocks since the request was taken, read only by the checks
  logic [wait_pkg::CNT_W-1:0] elapsed_r;
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      elapsed_r <= '0;
    // The request clock counts as the first clock of the access
    else if (take)
      elapsed_r <= 8'h01;
    else if (elapsed_r != 8'hFF)
      elapsed_r <= elapsed_r + 8'h01;
  end

  property p_len_ok;
    @(posedge sys_clk) disable iff (!rst_n)
    $rose(done_r) && $past(main_osc_running, 1) |-> elapsed_r == total_r;
  endproperty
  a_len_ok: assert property (p_len_ok) else $error("access length wrong");

  property p_wait_ok;
    @(posedge sys_clk) disable iff (!rst_n)
    take |=> last_r == 8'(($past(m_cur) + 8'h02) * $past(k_cur));
  endproperty
  a_wait_ok: assert property (p_wait_ok) else $error("wait count wrong");

  property p_set_ok;
    @(posedge sys_clk) disable iff (!rst_n)
    setting_we |=> m_cur == $past(setting_wdata[2:0]);
  endproperty
  a_set_ok: assert property (p_set_ok) else $error("m not from setting");

  property p_wd_two;
    @(posedge sys_clk) disable iff (!rst_n)
    cpu_sel == wait_pkg::SEL_WD_TWO && cpu_write |-> k_cur == 5'h03;
  endproperty
  a_wd_two: assert property (p_wd_two) else $error("watchdog two factor");

  property p_wd_one;
    @(posedge sys_clk) disable iff (!rst_n)
    cpu_sel == wait_pkg::SEL_WD_ONE && cpu_write |-> k_cur >= 5'h01 && k_cur <= 5'h05;
  endproperty
  a_wd_one: assert property (p_wd_one) else $error("watchdog one factor");

  property p_status;
    @(posedge sys_clk) disable iff (!rst_n)
    cpu_sel == wait_pkg::SEL_STATUS && !cpu_write |-> k_cur == 5'h01;
  endproperty
  a_status: assert property (p_status) else $error("status read factor");

  property p_rt_on;
    @(posedge sys_clk) disable iff (!rst_n)
    cpu_sel == wait_pkg::SEL_RT_BUF && rt_output_enable |-> k_cur == 5'h00;
  endproperty
  a_rt_on: assert property (p_rt_on) else $error("buffer wait when enabled");

  property p_stall;
    @(posedge sys_clk) disable iff (!rst_n)
    take |=> !ready_r throughout (state_r == ST_WAIT) [*2];
  endproperty
  a_stall: assert property (p_stall) else $error("ready during wait");

  property p_hang;
    @(posedge sys_clk) disable iff (!rst_n)
    state_r == ST_WAIT && !main_osc_running |=> state_r == ST_WAIT && !done_r;
  endproperty
  a_hang: assert property (p_hang) else $error("wait ended without clock");

  property p_reset_set;
    @(posedge sys_clk)
    $rose(rst_n) |-> setting_r == 8'h77;
  endproperty
  a_reset_set: assert property (p_reset_set) else $error("bad setting reset");

  c_plain: cover property (@(posedge sys_clk) take && k_cur == 5'h00);
  c_long: cover property (@(posedge sys_clk) take && k_cur > 5'h02);
  c_done: cover property (@(posedge sys_clk) done_r && !write_r);

endmodule : periph_wait_bridge
`default_nettype wire

// *** design/wait_factor_calc.sv ***
// Shared constants and the per-register wait factor calculator
`default_nettype none

package wait_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int SEL_W = 4;        // Register class code width
  localparam int K_W = 5;          // Wait factor width
  localparam int DIV_W = 6;        // CPU clocks per peripheral clock period
  localparam int CNT_W = 8;        // Access length counter width
  localparam int DATA_W = 16;      // Peripheral data width
  localparam int SET_W = 8;        // System wait setting width
  localparam int M_W = 3;          // Width of m field
  localparam int NUM_W = 10;       // Width of factor numerators

  // ----------------------------------------------------------------
  // Register classes seen on the peripheral bus
  // ----------------------------------------------------------------
  localparam logic [SEL_W-1:0] SEL_PLAIN = 4'h0;        // No extra wait
  localparam logic [SEL_W-1:0] SEL_WD_ONE = 4'h1;       // watchdog_one_mode
  localparam logic [SEL_W-1:0] SEL_WD_TWO = 4'h2;       // watchdog_two_mode
  localparam logic [SEL_W-1:0] SEL_TP_CMP = 4'h3;       // timer_p compare zero/one
  localparam logic [SEL_W-1:0] SEL_TP_CNT = 4'h4;       // timer_p_counter
  localparam logic [SEL_W-1:0] SEL_TM_CTL = 4'h5;       // timer zero/one control
  localparam logic [SEL_W-1:0] SEL_SER_BUF = 4'h6;      // serial_buffer_first..last
  localparam logic [SEL_W-1:0] SEL_STATUS = 4'h7;       // Serial and two-wire status
  localparam logic [SEL_W-1:0] SEL_RT_BUF = 4'h8;       // rt_output_buffer low/high
  localparam logic [SEL_W-1:0] SEL_CONV_CTL = 4'h9;     // Converter mode/channel/compare
  localparam logic [SEL_W-1:0] SEL_CONV_RES = 4'hA;     // converter_result (high)

  // ----------------------------------------------------------------
  // Fixed factors, limits and timing
  // ----------------------------------------------------------------
  localparam logic [K_W-1:0] K_ZERO = 5'h00;
  localparam logic [K_W-1:0] K_ONE = 5'h01;
  localparam logic [K_W-1:0] K_WD_TWO = 5'h03;
  localparam logic [K_W-1:0] K_WD_ONE_MAX = 5'h05;
  localparam logic [K_W-1:0] K_TP_WR_MAX = 5'h02;
  localparam logic [K_W-1:0] K_SER_MAX = 5'h12;         // Back-to-back writes
  localparam logic [K_W-1:0] K_SER_HIT_MAX = 5'h14;     // Collision with receive
  localparam logic [K_W-1:0] K_CONV_MAX = 5'h05;
  localparam logic [K_W-1:0] K_CONV_ALT_MAX = 5'h02;
  localparam logic [NUM_W-1:0] MUL_TWO = 10'h002;
  localparam logic [NUM_W-1:0] MUL_FIVE = 10'h005;
  localparam logic [NUM_W-1:0] SER_SUB_BASE = 10'h004;  // 4 + m term
  localparam logic [3:0] M_BASE = 4'h2;                 // 2 + m term
  localparam logic [3:0] ROUND_LIMIT = 4'h1;            // Remainder kept down
  localparam logic [CNT_W-1:0] BASE_CLOCKS = 8'h03;     // No-wait access length at m of 0
  localparam logic [SET_W-1:0] SET_RESET = 8'h77;
endpackage : wait_pkg

// Combinational wait factor k for the access being presented
module wait_factor_calc
(
  // Access description
  input wire logic [wait_pkg::SEL_W-1:0] sel,
  input wire logic is_write,
  input wire logic [wait_pkg::M_W-1:0] m,
  // Clock ratios and side conditions
  input wire logic [wait_pkg::DIV_W-1:0] main_div,
  input wire logic [wait_pkg::DIV_W-1:0] ser_div,
  input wire logic [wait_pkg::DIV_W-1:0] conv_div,
  input wire logic conv_on_main,
  input wire logic ser_rx_hit,
  input wire logic rt_output_enable,
  // Result
  output logic [wait_pkg::K_W-1:0] k
);

  // Quotient over (2 + m), a remainder of one CPU period or less drops
  function automatic logic [wait_pkg::K_W-1:0] round_k(
    input logic [wait_pkg::NUM_W-1:0] num,
    input logic [3:0] d,
    input logic [wait_pkg::K_W-1:0] lim);
    logic [wait_pkg::NUM_W-1:0] q;
    logic [wait_pkg::NUM_W-1:0] r;
    q = num / {6'h00, d};
    r = num % {6'h00, d};
    if (r > {6'h00, wait_pkg::ROUND_LIMIT})
      q = q + 10'h001;
    // Never above the table maximum
    round_k = (q > {5'h00, lim}) ? lim : q[wait_pkg::K_W-1:0];
  endfunction : round_k

  logic [3:0] d;                       // 2 + m
  logic [wait_pkg::NUM_W-1:0] n_main;  // Main period in CPU clocks
  logic [wait_pkg::NUM_W-1:0] n_ser;   // Serial period in CPU clocks
  logic [wait_pkg::NUM_W-1:0] n_conv;  // Converter period in CPU clocks
  logic [wait_pkg::NUM_W-1:0] ser_num;
  logic [wait_pkg::NUM_W-1:0] ser_sub;

  assign d = wait_pkg::M_BASE + {1'b0, m};
  assign n_main = {4'h0, main_div};
  assign n_ser = {4'h0, ser_div};
  assign n_conv = conv_on_main ? n_main : {4'h0, conv_div};
  assign ser_num = n_ser * wait_pkg::MUL_FIVE;
  assign ser_sub = wait_pkg::SER_SUB_BASE + {7'h00, m};

  // Factor selection per register class and direction
  always_comb
  begin
    k = wait_pkg::K_ZERO;
    unique case (sel)
      wait_pkg::SEL_WD_ONE:
        if (is_write)
          // Cap the quotient one below the maximum so the added one stays in range
          k = round_k(n_main * wait_pkg::MUL_TWO, d,
                      wait_pkg::K_WD_ONE_MAX - wait_pkg::K_ONE) + wait_pkg::K_ONE;
      wait_pkg::SEL_WD_TWO:
        if (is_write)
          k = wait_pkg::K_WD_TWO;
      wait_pkg::SEL_TP_CMP:
        if (is_write)
          k = round_k(n_main * wait_pkg::MUL_FIVE, d, wait_pkg::K_TP_WR_MAX);
        else
          k = wait_pkg::K_ONE;
      wait_pkg::SEL_TP_CNT:
        if (!is_write)
          k = wait_pkg::K_ONE;
      wait_pkg::SEL_TM_CTL:
        if (is_write)
          k = wait_pkg::K_ONE;
      wait_pkg::SEL_SER_BUF:
        if (is_write && ser_rx_hit)
          k = round_k(ser_num, d, wait_pkg::K_SER_HIT_MAX);
        else if (is_write)
          // Subtract the CPU's own access time, never below zero
          k = round_k((ser_num > ser_sub) ? ser_num - ser_sub : '0, d,
                      wait_pkg::K_SER_MAX);
      wait_pkg::SEL_STATUS:
        if (!is_write)
          k = wait_pkg::K_ONE;
      wait_pkg::SEL_RT_BUF:
        if (is_write && !rt_output_enable)
          k = wait_pkg::K_ONE;
      wait_pkg::SEL_CONV_CTL, wait_pkg::SEL_CONV_RES:
        if (is_write == (sel == wait_pkg::SEL_CONV_CTL))
          k = round_k(n_conv * wait_pkg::MUL_TWO, d,
                      conv_on_main ? wait_pkg::K_CONV_ALT_MAX - wait_pkg::K_ONE
                                   : wait_pkg::K_CONV_MAX - wait_pkg::K_ONE)
              + wait_pkg::K_ONE;
      default:
        k = wait_pkg::K_ZERO;
    endcase
  end

endmodule : wait_factor_calc
`default_nettype wire

// *** testbench/periph_model.sv ***
// Peripheral-side responder that answers the bridge's read strobes
`default_nettype none

module periph_model
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Strobe side of the bridge
  input wire logic per_strobe,
  input wire logic per_write,
  input wire logic [wait_pkg::SEL_W-1:0] per_sel,
  input wire logic cpu_done,
  // Read data back to the bridge
  output logic [wait_pkg::DATA_W-1:0] per_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Read tracking
  // ----------------------------------------------------------------
  logic busy_r;                              // Read in flight
  logic busy_nxt;
  logic [wait_pkg::DATA_W-1:0] word_r;       // Word for this read
  logic [wait_pkg::DATA_W-1:0] word_nxt;

  // Capture a read on the strobe, let go of the bus after done
  always_comb
  begin
    busy_nxt = busy_r;
    word_nxt = word_r;
    if (per_strobe && !per_write)
    begin
      busy_nxt = 1'b1;
      word_nxt = {12'hC3A, per_sel};
    end
    else if (cpu_done)
      busy_nxt = 1'b0;
  end

  // Register the read state
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      busy_r <= 1'b0;
      word_r <= 16'h0000;
    end
    else
    begin
      busy_r <= busy_nxt;
      word_r <= word_nxt;
    end
  end

  // Idle bus shows the inverse, so a stale word can never pass
  assign per_rdata = busy_r ? word_r : ~word_r;
endmodule : periph_model

`default_nettype wire

// *** testbench/periph_wait_bridge_tb.sv ***
// Self-checking bench for the peripheral wait bridge
`default_nettype none

module periph_wait_bridge_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic cpu_req = 1'b0;
  logic [wait_pkg::SEL_W-1:0] cpu_sel = 4'h0;
  logic cpu_write = 1'b0;
  logic [wait_pkg::DATA_W-1:0] cpu_wdata = 16'h0000;
  logic setting_we = 1'b0;
  logic [wait_pkg::SET_W-1:0] setting_wdata = 8'h00;
  logic [wait_pkg::DIV_W-1:0] main_div = 6'h14;    // Large ratios hit the caps
  logic [wait_pkg::DIV_W-1:0] ser_div = 6'h14;
  logic [wait_pkg::DIV_W-1:0] conv_div = 6'h14;
  logic conv_on_main = 1'b0;
  logic ser_rx_hit = 1'b0;
  logic rt_output_enable = 1'b0;
  logic main_osc_running = 1'b1;
  logic [wait_pkg::DATA_W-1:0] per_rdata;
  logic cpu_ready;
  logic cpu_done;
  logic per_strobe;
  logic per_write;
  logic [wait_pkg::DATA_W-1:0] cpu_rdata;
  logic [wait_pkg::DATA_W-1:0] per_wdata;
  logic [wait_pkg::SEL_W-1:0] per_sel;
  logic [wait_pkg::SET_W-1:0] system_wait_setting;
  logic [wait_pkg::CNT_W-1:0] last_wait;
  int n_fail = 0;
  int total_checks = 0;
  int m_cur = 7;      // Reset setting gives m of 7
  int cycles = 0;

  // ----------------------------------------------------------------
  // Design and peripheral model
  // ----------------------------------------------------------------
  periph_wait_bridge periph_wait_bridge_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .cpu_req(cpu_req), .cpu_sel(cpu_sel), .cpu_write(cpu_write), .cpu_wdata(cpu_wdata),
    .setting_we(setting_we), .setting_wdata(setting_wdata), .main_div(main_div),
    .ser_div(ser_div), .conv_div(conv_div), .conv_on_main(conv_on_main),
    .ser_rx_hit(ser_rx_hit), .rt_output_enable(rt_output_enable),
    .main_osc_running(main_osc_running), .per_rdata(per_rdata), .cpu_ready(cpu_ready),
    .cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .per_strobe(per_strobe),
    .per_write(per_write), .per_sel(per_sel), .per_wdata(per_wdata),
    .system_wait_setting(system_wait_setting), .last_wait(last_wait));
  periph_model periph_model_i (.sys_clk(sys_clk), .rst_n(rst_n), .per_strobe(per_strobe),
    .per_write(per_write), .per_sel(per_sel), .cpu_done(cpu_done), .per_rdata(per_rdata));

  // ----------------------------------------------------------------
  // Clock, timeout and shared tasks
  // ----------------------------------------------------------------
  always #2 sys_clk = ~sys_clk;

  // Verdict and end of run
  task automatic complete_run;
    if (n_fail == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // A hung wait must not stall the run forever
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end

  // Compare one value, flags zero-extended
  task automatic chk_val(input string nm, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk_val

  // Synchronous reset held for four cycles
  task automatic do_reset;
    rst_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    m_cur = 7;
  endtask : do_reset

  // One-cycle setting write; only bits 2..0 make m
  task automatic set_wait(input logic [7:0] v);
    @(negedge sys_clk);
    setting_we = 1'b1;
    setting_wdata = v;
    @(negedge sys_clk);
    setting_we = 1'b0;
    m_cur = int'(v[2:0]);
    chk_val("wait setting", {8'h00, v}, {8'h00, system_wait_setting});
  endtask : set_wait

  // One access, timed from the take edge to the done pulse
  task automatic access(input logic [3:0] sel, input logic wr, input int k);
    int t_exp;
    int n;
    t_exp = 3 + m_cur + (2 + m_cur) * k;
    @(negedge sys_clk);
    cpu_req = 1'b1;
    cpu_sel = sel;
    cpu_write = wr;
    cpu_wdata = {12'h5A0, sel};
    @(negedge sys_clk);
    cpu_req = 1'b0;
    chk_val("strobe", 16'h0001, {15'h0000, per_strobe});
    chk_val("strobe class", {12'h000, sel}, {12'h000, per_sel});
    chk_val("strobe direction", {15'h0000, wr}, {15'h0000, per_write});
    n = 1;
    // Ready stays low for the whole stretch
    while (cpu_done !== 1'b1 && n < 300)
    begin
      chk_val("ready in wait", 16'h0000, {15'h0000, cpu_ready});
      @(negedge sys_clk);
      n++;
    end
    chk_val("access clocks", 16'(t_exp), 16'(n));
    chk_val("inserted wait", 16'((2 + m_cur) * k), {8'h00, last_wait});
    chk_val("ready at done", 16'h0001, {15'h0000, cpu_ready});
    if (wr)
      chk_val("write data", {12'h5A0, sel}, per_wdata);
    else
      chk_val("read data", {12'hC3A, sel}, cpu_rdata);
  endtask : access

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    do_reset();
    chk_val("reset ready", 16'h0001, {15'h0000, cpu_ready});
    chk_val("reset setting", 16'h0077, {8'h00, system_wait_setting});
    chk_val("reset last wait", 16'h0000, {8'h00, last_wait});
    access(wait_pkg::SEL_PLAIN, 1'b0, 0);
    access(wait_pkg::SEL_WD_TWO, 1'b1, 3);
    // Same classes at m of 0 and 1; upper bits of the setting ignored
    for (int i = 0; i < 2; i++)
    begin
      set_wait(i == 0 ? 8'h00 : 8'hF9);
      access(wait_pkg::SEL_PLAIN, 1'b0, 0);
      access(wait_pkg::SEL_WD_TWO, 1'b1, 3);
      access(wait_pkg::SEL_STATUS, 1'b0, 1);
      access(wait_pkg::SEL_TP_CNT, 1'b0, 1);
      access(wait_pkg::SEL_TP_CMP, 1'b0, 1);
      access(wait_pkg::SEL_TP_CMP, 1'b1, 2);
      access(wait_pkg::SEL_TM_CTL, 1'b1, 1);
      access(wait_pkg::SEL_RT_BUF, 1'b1, 1);
      rt_output_enable = 1'b1;
      access(wait_pkg::SEL_RT_BUF, 1'b1, 0);
      rt_output_enable = 1'b0;
      access(wait_pkg::SEL_WD_ONE, 1'b1, 5);
      access(wait_pkg::SEL_SER_BUF, 1'b1, 18);
      ser_rx_hit = 1'b1;
      access(wait_pkg::SEL_SER_BUF, 1'b1, 20);
      ser_rx_hit = 1'b0;
      access(wait_pkg::SEL_CONV_CTL, 1'b1, 5);
      access(wait_pkg::SEL_CONV_RES, 1'b0, 5);
      conv_on_main = 1'b1;
      access(wait_pkg::SEL_CONV_RES, 1'b0, 2);
      conv_on_main = 1'b0;
    end
    // Remainder of 2 rounds up, remainder of 1 rounds down, at m of 1, then plus one
    main_div = 6'h04;
    access(wait_pkg::SEL_WD_ONE, 1'b1, 4);
    main_div = 6'h02;
    access(wait_pkg::SEL_WD_ONE, 1'b1, 2);
    // Without the main clock the wait hangs until reset
    main_osc_running = 1'b0;
    @(negedge sys_clk);
    cpu_req = 1'b1;
    cpu_sel = wait_pkg::SEL_WD_TWO;
    cpu_write = 1'b1;
    @(negedge sys_clk);
    cpu_req = 1'b0;
    repeat (100) @(negedge sys_clk);
    chk_val("hung ready", 16'h0000, {15'h0000, cpu_ready});
    chk_val("hung done", 16'h0000, {15'h0000, cpu_done});
    do_reset();
    main_osc_running = 1'b1;
    chk_val("released ready", 16'h0001, {15'h0000, cpu_ready});
    chk_val("setting after reset", 16'h0077, {8'h00, system_wait_setting});
    access(wait_pkg::SEL_STATUS, 1'b0, 1);
    complete_run();
  end
endmodule : periph_wait_bridge_tb

`default_nettype wire
